// ---- phyrp_regs.vh ----
// How it works
// - per-port loop block flag sets on loop-disable, clears on bus reset or disconnect.
// - standby flag is 1 while port is in standby, per port at standby_o, port 0 only in register 5.
// - deep port-off acts only when disabled; forces connected and receive-ok to 0.
// - hard-disabled port stops toning; clearing the bit renegotiates speed.
// - page chooser value 1 maps identification page into paged addresses.
// - compliance at 1000, 1001 reserved, maker 1010-1100, part 1101-1111, MSB first.
// - compliance level reads 02h.
// - 24-bit maker code over three read-only byte registers.
// - 24-bit part code over three read-only bytes, most significant first.
// - page chooser value 7 maps vendor-dependent page.
// - writing 1 to bit 0 at vendor address 1110 forces full hard reset.
// - soft hard-reset bit always reads 0.
// - after reset, power class loads from three straps into self-ID bits 21-23.
// - later write to register 4 power class replaces strap default.
// - power class is a 3-bit code, all eight values stored unchanged.
`ifndef PHYRP_REGS_VH
`define PHYRP_REGS_VH
`define PHYRP_PG_ID        3'h1
`define PHYRP_PG_VD        3'h7
`define PHYRP_A_COMPL      4'h8
`define PHYRP_A_MK_HI      4'ha
`define PHYRP_A_MK_MID     4'hb
`define PHYRP_A_MK_LO      4'hc
`define PHYRP_A_PC_HI      4'hd
`define PHYRP_A_PC_MID     4'he
`define PHYRP_A_PC_LO      4'hf
`define PHYRP_A_SWR        4'he
`define PHYRP_A_PWR        4'h4
`define PHYRP_A_PAGE       4'h7
`define PHYRP_A_PSEL       4'h0
`define PHYRP_A_PORTCTL    4'h1
`define PHYRP_A_INT_ST     4'h2
`define PHYRP_A_INT_MASK   4'h3
`define PHYRP_A_PORTST     4'h5
`define PHYRP_COMPLIANCE   8'h02
`define PHYRP_PWR_LSB      5
`define PHYRP_PAGE_LSB     5
`define PHYRP_SWR_BIT      0
`define PHYRP_PULSE_CYC    4'h4
`endif

// ---- phyrp_port_stat.v ----
`timescale 1ns/1ps
module phyrp_port_stat (
    // clock and reset
    input  wire clk_i,
    input  wire rst_n_i,
    // port events
    input  wire loop_dis_i,
    input  wire bus_reset_i,
    input  wire connect_i,
    input  wire standby_i,
    input  wire disabled_i,
    input  wire con_raw_i,
    input  wire receive_ok_flag_raw_i,
    input  wire deep_off_i,
    // status
    output reg  loop_block_o,
    output reg  standby_o,
    output reg  con_o,
    output reg  receive_ok_flag_o,
    output reg  tone_en_o,
    output reg  renegotiate_o
);
    reg  hard_off_r;
    wire hard_off_nxt = deep_off_i & disabled_i;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            loop_block_o      <= 1'b0;
            standby_o         <= 1'b0;
            con_o             <= 1'b0;
            receive_ok_flag_o <= 1'b0;
            tone_en_o         <= 1'b1;
            renegotiate_o     <= 1'b0;
            hard_off_r        <= 1'b0;
        end else begin
            if (bus_reset_i || !connect_i)
                loop_block_o <= 1'b0;
            else if (loop_dis_i)
                loop_block_o <= 1'b1;
            standby_o <= standby_i;
            con_o             <= con_raw_i & ~hard_off_nxt;
            receive_ok_flag_o <= receive_ok_flag_raw_i & ~hard_off_nxt;
            tone_en_o     <= ~hard_off_nxt;
            hard_off_r    <= hard_off_nxt;
            renegotiate_o <= hard_off_r & ~hard_off_nxt;
        end
    end
endmodule // phyrp_port_stat

// ---- phyrp_pages.v ----
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "phyrp_regs.vh"
module phyrp_pages #(
    parameter          NPORT     = 3,
    parameter [23:0]   MAKER_ID  = 24'h123456, // arbitrary value
    parameter [23:0]   PART_ID   = 24'habcdef  // arbitrary value
) (
    // clock and reset
    input  wire             clk_i,
    input  wire             rstn_i,
    // register port
    input  wire [3:0]       addr_i,
    input  wire [7:0]       wdata_i,
    input  wire             wr_i,
    input  wire             rd_i,
    output reg  [7:0]       rdata_o,
    // straps
    input  wire             power_class_strap_0_i,
    input  wire             power_class_strap_1_i,
    input  wire             power_class_strap_2_i,
    // per-port state
    input  wire [NPORT-1:0] loop_dis_i,
    input  wire [NPORT-1:0] bus_reset_i,
    input  wire [NPORT-1:0] connect_i,
    input  wire [NPORT-1:0] standby_i,
    input  wire [NPORT-1:0] disabled_i,
    input  wire [NPORT-1:0] con_raw_i,
    input  wire [NPORT-1:0] receive_ok_flag_raw_i,
    // outputs
    output reg  [NPORT-1:0] loop_block_o,
    output reg  [NPORT-1:0] standby_o,
    output reg  [NPORT-1:0] con_o,
    output reg  [NPORT-1:0] receive_ok_flag_o,
    output reg  [NPORT-1:0] tone_en_o,
    output reg  [NPORT-1:0] renegotiate_o,
    output reg  [2:0]       power_class_o,
    output reg              hard_reset_o,
    output reg              irq_o
);
    reg  [1:0]       rst_sync_r;
    wire             rst_n = rst_sync_r[1];
    reg  [3:0]       swr_cnt_r;
    reg  [2:0]       page_r;
    reg  [2:0]       psel_r;
    reg  [NPORT-1:0] deep_off_r;
    reg  [NPORT-1:0] int_st_r;
    reg  [NPORT-1:0] int_mask_r;
    reg              strap_done_r;
    reg  [2:0]       strap_s1_r;
    reg  [2:0]       strap_s2_r;
    reg  [NPORT-1:0] in_s1_r [0:6];
    reg  [NPORT-1:0] in_s2_r [0:6];
    reg  [7:0]       rd_nxt;
    wire [NPORT-1:0] lb_w;
    wire [NPORT-1:0] sb_w;
    wire [NPORT-1:0] con_w;
    wire [NPORT-1:0] rx_w;
    wire [NPORT-1:0] tone_w;
    wire [NPORT-1:0] reneg_w;
    wire             swr_hit;

    // reset sync; soft hard reset also drops it
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i)
            rst_sync_r <= 2'b00;
        else if (swr_cnt_r != 4'h0)
            rst_sync_r <= 2'b00;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end

    assign swr_hit = wr_i && (page_r == `PHYRP_PG_VD) &&
                     (addr_i == `PHYRP_A_SWR) && wdata_i[`PHYRP_SWR_BIT];
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i)
            swr_cnt_r <= 4'h0;
        else if (swr_hit && rst_n)
            swr_cnt_r <= `PHYRP_PULSE_CYC;
        else if (swr_cnt_r != 4'h0)
            swr_cnt_r <= swr_cnt_r - 4'h1;
    end

    // input synchronisers; pin reset only, so straps are valid at release
    integer k;
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (k = 0; k < 7; k = k + 1) begin
                in_s1_r[k] <= {NPORT{1'b0}};
                in_s2_r[k] <= {NPORT{1'b0}};
            end
            strap_s1_r <= 3'h0;
            strap_s2_r <= 3'h0;
        end else begin
            in_s1_r[0] <= loop_dis_i;
            in_s1_r[1] <= bus_reset_i;
            in_s1_r[2] <= connect_i;
            in_s1_r[3] <= standby_i;
            in_s1_r[4] <= disabled_i;
            in_s1_r[5] <= con_raw_i;
            in_s1_r[6] <= receive_ok_flag_raw_i;
            for (k = 0; k < 7; k = k + 1)
                in_s2_r[k] <= in_s1_r[k];
            strap_s1_r <= {power_class_strap_2_i, power_class_strap_1_i,
                           power_class_strap_0_i};
            strap_s2_r <= strap_s1_r;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NPORT; g = g + 1) begin : g_port
            phyrp_port_stat u_port (
                .clk_i             (clk_i),
                .rst_n_i           (rst_n),
                .loop_dis_i        (in_s2_r[0][g]),
                .bus_reset_i       (in_s2_r[1][g]),
                .connect_i         (in_s2_r[2][g]),
                .standby_i         (in_s2_r[3][g]),
                .disabled_i        (in_s2_r[4][g]),
                .con_raw_i         (in_s2_r[5][g]),
                .receive_ok_flag_raw_i        (in_s2_r[6][g]),
                .deep_off_i        (deep_off_r[g]),
                .loop_block_o      (lb_w[g]),
                .standby_o         (sb_w[g]),
                .con_o             (con_w[g]),
                .receive_ok_flag_o (rx_w[g]),
                .tone_en_o         (tone_w[g]),
                .renegotiate_o     (reneg_w[g])
            );
        end
    endgenerate

    // register writes
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            page_r       <= 3'h0;
            psel_r       <= 3'h0;
            deep_off_r   <= {NPORT{1'b0}};
            int_mask_r   <= {NPORT{1'b0}};
            power_class_o <= 3'h0;
            strap_done_r <= 1'b0;
        end else begin
            if (!strap_done_r) begin
                power_class_o <= strap_s2_r;
                strap_done_r  <= 1'b1;
            end
            if (wr_i) begin
                if (addr_i == `PHYRP_A_PAGE)
                    page_r <= wdata_i[`PHYRP_PAGE_LSB+2:`PHYRP_PAGE_LSB];
                else if (addr_i == `PHYRP_A_PWR)
                    power_class_o <= wdata_i[`PHYRP_PWR_LSB+2:`PHYRP_PWR_LSB];
                else if (addr_i == `PHYRP_A_PSEL)
                    psel_r <= wdata_i[2:0];
                else if (addr_i == `PHYRP_A_PORTCTL && page_r == 3'h0)
                    deep_off_r <= wdata_i[NPORT-1:0];
                else if (addr_i == `PHYRP_A_INT_MASK && page_r == 3'h0)
                    int_mask_r <= wdata_i[NPORT-1:0];
            end
        end
    end

    // sticky status: loop block and renegotiation events, w1c, set wins
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n)
            int_st_r <= {NPORT{1'b0}};
        else if (wr_i && addr_i == `PHYRP_A_INT_ST && page_r == 3'h0)
            int_st_r <= (int_st_r & ~wdata_i[NPORT-1:0]) |
                        (lb_w & ~loop_block_o) | reneg_w;
        else
            int_st_r <= int_st_r | (lb_w & ~loop_block_o) | reneg_w;
    end

    // read mux
    always @* begin
        rd_nxt = 8'h00;
        if (page_r == `PHYRP_PG_ID) begin
            if (addr_i == `PHYRP_A_COMPL)
                rd_nxt = `PHYRP_COMPLIANCE;
            else if (addr_i == `PHYRP_A_MK_HI)
                rd_nxt = MAKER_ID[23:16];
            else if (addr_i == `PHYRP_A_MK_MID)
                rd_nxt = MAKER_ID[15:8];
            else if (addr_i == `PHYRP_A_MK_LO)
                rd_nxt = MAKER_ID[7:0];
            else if (addr_i == `PHYRP_A_PC_HI)
                rd_nxt = PART_ID[23:16];
            else if (addr_i == `PHYRP_A_PC_MID)
                rd_nxt = PART_ID[15:8];
            else if (addr_i == `PHYRP_A_PC_LO)
                rd_nxt = PART_ID[7:0];
        end else if (page_r == `PHYRP_PG_VD) begin
            rd_nxt = 8'h00;
        end else if (addr_i == `PHYRP_A_PAGE)
            rd_nxt = {page_r, 5'h00};
        else if (addr_i == `PHYRP_A_PWR)
            rd_nxt = {power_class_o, 5'h00};
        else if (addr_i == `PHYRP_A_PSEL)
            rd_nxt = {5'h00, psel_r};
        else if (addr_i == `PHYRP_A_PORTCTL)
            rd_nxt = {{(8-NPORT){1'b0}}, deep_off_r};
        else if (addr_i == `PHYRP_A_INT_ST)
            rd_nxt = {{(8-NPORT){1'b0}}, int_st_r};
        else if (addr_i == `PHYRP_A_INT_MASK)
            rd_nxt = {{(8-NPORT){1'b0}}, int_mask_r};
        else if (addr_i == `PHYRP_A_PORTST)
            rd_nxt = {lb_w[0], sb_w[0], con_w[0], rx_w[0],
                      {(4-NPORT){1'b0}}, lb_w[NPORT-1:1], 1'b0};
    end

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o           <= 8'h00;
            loop_block_o      <= {NPORT{1'b0}};
            standby_o         <= {NPORT{1'b0}};
            con_o             <= {NPORT{1'b0}};
            receive_ok_flag_o <= {NPORT{1'b0}};
            tone_en_o         <= {NPORT{1'b1}};
            renegotiate_o     <= {NPORT{1'b0}};
            irq_o             <= 1'b0;
        end else begin
            rdata_o           <= rd_i ? rd_nxt : 8'h00;
            loop_block_o      <= lb_w;
            standby_o         <= sb_w;
            con_o             <= con_w;
            receive_ok_flag_o <= rx_w;
            tone_en_o         <= tone_w;
            renegotiate_o     <= reneg_w;
            irq_o             <= |(int_st_r & int_mask_r);
        end
    end

    // hard reset indicator, from flop
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i)
            hard_reset_o <= 1'b1;
        else
            hard_reset_o <= ~rst_n;
    end
endmodule // phyrp_pages

// ---- phyrp_pages_chk.sv ----
`timescale 1ns/1ps
module phyrp_pages_chk #(
    parameter          NPORT    = 3,
    parameter [23:0]   MAKER_ID = 24'h123456,
    parameter [23:0]   PART_ID  = 24'habcdef
) (
    // clock, reset and register port
    input  wire             clk_i,
    input  wire             rstn_i,
    input  wire [3:0]       addr_i,
    input  wire [7:0]       wdata_i,
    input  wire             wr_i,
    input  wire             rd_i,
    input  wire [7:0]       rdata_o,
    // straps and port state
    input  wire             power_class_strap_0_i,
    input  wire             power_class_strap_1_i,
    input  wire             power_class_strap_2_i,
    input  wire [NPORT-1:0] bus_reset_i,
    input  wire [NPORT-1:0] standby_i,
    // outputs
    input  wire [NPORT-1:0] loop_block_o,
    input  wire [NPORT-1:0] standby_o,
    input  wire [2:0]       power_class_o,
    input  wire             hard_reset_o
);
    reg [2:0] pg_r;
    reg [2:0] pw_r;
    wire [2:0] strap = {power_class_strap_2_i, power_class_strap_1_i,
                        power_class_strap_0_i};
    // page as software last chose it
    always @(posedge clk_i or negedge rstn_i)
        if (!rstn_i) pg_r <= 3'h0;
        else if (hard_reset_o) pg_r <= 3'h0;
        else if (wr_i && addr_i == 4'h7) pg_r <= wdata_i[7:5];
    always @(posedge clk_i) pw_r <= wdata_i[7:5];
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i || hard_reset_o);
    a_read_idle: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero outside read answer");
    a_compl_byte: assert property (rd_i && pg_r == 3'h1 && addr_i == 4'h8
        |=> rdata_o == 8'h02) else $error("bad compliance");
    a_maker_hi: assert property (rd_i && pg_r == 3'h1 && addr_i == 4'ha
        |=> rdata_o == MAKER_ID[23:16]) else $error("bad maker");
    a_part_lo: assert property (rd_i && pg_r == 3'h1 && addr_i == 4'hf
        |=> rdata_o == PART_ID[7:0]) else $error("bad part");
    a_swr_read0: assert property (rd_i && pg_r == 3'h7 && addr_i == 4'he
        |=> !rdata_o[0]) else $error("reset bit reads one");
    a_swr_reset: assert property (wr_i && pg_r == 3'h7 && addr_i == 4'he
        && wdata_i[0] |-> ##[1:4] hard_reset_o)
        else $error("soft reset not taken");
    a_pwr_write: assert property (wr_i && addr_i == 4'h4
        |=> power_class_o == pw_r) else $error("power class");
    a_pwr_strap: assert property ($fell(hard_reset_o)
        |-> ##[0:4] power_class_o == strap)
        else $error("strap power class not loaded");
    a_loop_clear: assert property (bus_reset_i[0] [*8]
        |-> !loop_block_o[0]) else $error("loop flag kept");
    a_stby_follow: assert property ($stable(standby_i[0]) [*8]
        |-> standby_o[0] == standby_i[0])
        else $error("standby flag wrong");
    c_swr: cover property (wr_i && pg_r == 3'h7 && addr_i == 4'he);
    c_id: cover property (rd_i && pg_r == 3'h1);
    c_loop: cover property ($rose(loop_block_o[0]));
endmodule // phyrp_pages_chk
bind phyrp_pages phyrp_pages_chk #(.NPORT(NPORT), .MAKER_ID(MAKER_ID),
    .PART_ID(PART_ID)) chk_i (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .power_class_strap_0_i, .power_class_strap_1_i,
    .power_class_strap_2_i, .bus_reset_i, .standby_i, .loop_block_o,
    .standby_o, .power_class_o, .hard_reset_o);

// ---- phyrp_link_mdl.sv ----
`timescale 1ns/1ps
module phyrp_link_mdl (
    // clock and read data
    input  wire       clk_i,
    input  wire [7:0] rdata_i,
    // register requests
    output reg  [3:0] addr_o,
    output reg  [7:0] wdata_o,
    output reg        wr_o,
    output reg        rd_o
);
    initial begin
        addr_o = 4'h0;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge clk_i);
            addr_o  <= a;
            wdata_o <= d;
            wr_o    <= 1'b1;
            @(posedge clk_i);
            wr_o    <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, output [7:0] d);
        begin
            @(posedge clk_i);
            addr_o <= a;
            rd_o   <= 1'b1;
            @(posedge clk_i);
            rd_o   <= 1'b0;
            @(posedge clk_i);
            d = rdata_i;
        end
    endtask
    task pg(input [2:0] p);
        wr(4'h7, {p, 5'h00});
    endtask
endmodule // phyrp_link_mdl

// ---- phyrp_pages_tb.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks = num_checks + 1; \
    if ((g) !== (e)) begin error_cnt = error_cnt + 1; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module phyrp_pages_tb;
    localparam [23:0] MK = 24'h5a1c3e; // arbitrary value
    localparam [23:0] PT = 24'h47b902; // arbitrary value
    reg        clk_i = 1'b0;
    reg        rstn_i = 1'b0;
    reg  [2:0] ps = 3'h0, ld = 3'h0, br = 3'h0, cn = 3'h7, sb = 3'h0;
    reg  [2:0] ds = 3'h0, cr = 3'h7, rr = 3'h7;
    wire [3:0] addr;
    wire [7:0] wdata, rdata;
    wire       wr, rd, hr, irq;
    wire [2:0] lb, so, co, ro, te, rn, pc;
    integer    error_cnt = 0, num_checks = 0, seed = 25, i;
    reg  [7:0] d, v;
    initial forever #2.5 clk_i = ~clk_i;
    phyrp_link_mdl lnk (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    phyrp_pages #(.NPORT(3), .MAKER_ID(MK), .PART_ID(PT)) phyrp_pages_i (
        .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .power_class_strap_0_i(ps[0]), .power_class_strap_1_i(ps[1]),
        .power_class_strap_2_i(ps[2]), .loop_dis_i(ld), .bus_reset_i(br),
        .connect_i(cn), .standby_i(sb), .disabled_i(ds), .con_raw_i(cr),
        .receive_ok_flag_raw_i(rr), .loop_block_o(lb), .standby_o(so), .con_o(co),
        .receive_ok_flag_o(ro), .tone_en_o(te), .renegotiate_o(rn),
        .power_class_o(pc), .hard_reset_o(hr), .irq_o(irq));
    function [7:0] exp_b(input [2:0] p, input [3:0] a);
        case ({p, a})
            7'h18: exp_b = 8'h02;
            7'h1a: exp_b = MK[23:16];
            7'h1b: exp_b = MK[15:8];
            7'h1c: exp_b = MK[7:0];
            7'h1d: exp_b = PT[23:16];
            7'h1e: exp_b = PT[15:8];
            7'h1f: exp_b = PT[7:0];
            default: exp_b = 8'h00;
        endcase
    endfunction
    task cyc(input integer n);
        repeat (n) @(posedge clk_i);
    endtask
    task page_sweep(input [2:0] p);
        for (i = 8; i < 16; i = i + 1) begin
            lnk.rd(i[3:0], d);
            `CHK("page byte", exp_b(p, i[3:0]), d)
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", num_checks, error_cnt);
            if (error_cnt == 0 && num_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    initial begin
        #200000;
        error_cnt = error_cnt + 1;
        end_sim;
    end
    initial begin
        ps = $random(seed);
        cyc(12);
        rstn_i <= 1'b1;
        cyc(8);
        `CHK("strap pwr", ps, pc)
        lnk.pg(3'h1);
        page_sweep(3'h1);
        repeat (8) begin
            v = 8'h08 + ($random(seed) & 8'h07);
            lnk.wr(v[3:0], $random(seed));
        end
        page_sweep(3'h1);
        $display("id page done");
        lnk.pg(3'h7);
        lnk.wr(4'he, 8'hfe);
        page_sweep(3'h7);
        $display("vendor page done");
        for (i = 0; i < 8; i = i + 1) begin
            v = {i[2:0], 5'h00} | ($random(seed) & 8'h1f);
            lnk.wr(4'h4, v);
            cyc(1);
            `CHK("pwr out", i[2:0], pc)
        end
        lnk.pg(3'h0);
        lnk.rd(4'h4, d);
        `CHK("pwr read", 3'h7, d[7:5])
        lnk.wr(4'h4, {~ps, 5'h00});
        lnk.pg(3'h7);
        lnk.wr(4'he, 8'h01);
        i = 0;
        while (hr !== 1'b1 && i < 8) begin cyc(1); i = i + 1; end
        `CHK("soft reset", 1'b1, hr)
        while (hr !== 1'b0 && i < 40) begin cyc(1); i = i + 1; end
        cyc(8);
        lnk.rd(4'h4, d);
        `CHK("pwr after swr", ps, d[7:5])
        $display("power class done");
        sb <= $random(seed);
        ld <= 3'h1;
        cyc(8);
        `CHK("standby", sb, so)
        `CHK("loop set", 1'b1, lb[0])
        ld <= 3'h0;
        br <= 3'h1;
        cyc(8);
        `CHK("loop bus reset", 1'b0, lb[0])
        br <= 3'h0;
        ld <= 3'h1;
        cyc(8);
        `CHK("loop set again", 1'b1, lb[0])
        ld <= 3'h0;
        cn <= 3'h6;
        cyc(8);
        `CHK("loop disconnect", 1'b0, lb[0])
        cn <= 3'h7;
        lnk.wr(4'h3, 8'h00);
        cyc(2);
        d[0] = irq;
        lnk.wr(4'h3, 8'hff);
        cyc(2);
        `CHK("irq mask", 1'b1, d[0] ^ irq)
        lnk.wr(4'h2, 8'hff);
        cyc(2);
        `CHK("irq clear", 1'b0, irq)
        $display("port status done");
        lnk.wr(4'h1, 8'h01);
        cyc(8);
        `CHK("deep off idle", 6'h3f, {co[0], te[0], ro[0], 3'h7})
        ds <= 3'h1;
        cyc(8);
        `CHK("deep off", 4'h8, {co[1], co[0], ro[0], te[0]})
        lnk.wr(4'h1, 8'h00);
        d = 8'h00;
        repeat (12) begin cyc(1); d[0] = d[0] | rn[0]; end
        `CHK("renegotiate", 1'b1, d[0])
        `CHK("tone back", 1'b1, te[0])
        $display("deep off done");
        end_sim;
    end
endmodule // phyrp_pages_tb
